// File: hpp_periph_model.sv
// behavioural printer answering the host parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_periph_model (
	// clock and reset
	input	wire logic		clk,
	input	wire logic		reset,
	// scenario knobs
	input	wire logic		hold_busy,
	input	wire logic		go_online,
	input	wire logic		jam,
	input	wire logic		fail,
	input	wire logic		powered,
	input	wire logic		answer,
	input	wire logic		slow,
	input	wire logic		send,
	// port pins
	input	wire logic		data_strobe_n,
	output	logic			byte_accepted_n,
	output	logic			peripheral_not_ready,
	output	logic			paper_path_fault,
	output	logic			peripheral_online,
	output	logic			peripheral_problem_n,
	output	logic			peripheral_valid,
	output	logic [7:0]		data_drv
);
	// ------------------------------------------------------------
	// byte handling
	// ------------------------------------------------------------
	logic [6:0]	cnt_q;
	logic		busy_q;
	logic		stb_q;
	logic		snd_q;
	logic [6:0]	dly;
	// acks land after the hold phase, slow ones near the timeout
	assign dly = slow ? 7'h46 : 7'h34;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 7'h00;
			busy_q <= 1'b0;
			stb_q <= 1'b1;
			snd_q <= 1'b0;
			data_drv <= 8'h00;
		end else begin
			stb_q <= data_strobe_n;
			snd_q <= send;
			// released lines change every cycle unless send holds them at 8'hC6
			if (send)
				data_drv <= 8'hC6;
			else
				data_drv <= data_drv + 8'h3B;
			if (!data_strobe_n)
				busy_q <= 1'b1;
			if (data_strobe_n && !stb_q) begin
				cnt_q <= answer ? 7'h01 : 7'h00;
				busy_q <= answer;
			end else if (send && !snd_q && cnt_q == 7'h00) begin
				cnt_q <= 7'h01;
			end else if (cnt_q == dly + 7'h05) begin
				cnt_q <= 7'h00;
				busy_q <= 1'b0;
			end else if (cnt_q != 7'h00)
				cnt_q <= cnt_q + 7'h01;
		end
	end
	assign byte_accepted_n = !(cnt_q >= dly && cnt_q < dly + 7'h05);
	assign peripheral_not_ready = busy_q | hold_busy;
	assign paper_path_fault = jam;
	assign peripheral_online = go_online;
	assign peripheral_problem_n = !(jam | fail);
	assign peripheral_valid = powered;
endmodule : hpp_periph_model
`default_nettype wire

// File: hpp_pkg.sv
// package of constants and carrier types for the host parallel port
// How it works
// - peripheral_init_n is open drain, active low, and low starts the peripheral's initialisation.
// - peripheral_choose_n goes low to select the peripheral and stays high otherwise.
// - the port drives the data lines in compatibility and negotiation, leaves them in nibble, and shares them otherwise.
// - transfer_direction is low for peripheral to host and high for host to peripheral.
// - host_valid is high only while all other host-driven signals are valid.
// - the port offers compatibility, nibble, byte, EPP 1.9, ECP with and without RLE, and FIFO modes.
// - data_strobe_n goes low to latch a byte, with the data lines held valid throughout.
// - auto_feed_n is an active-low output whose meaning depends on the peripheral.
package hpp_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SETUP_NS        = 500;
	localparam int STROBE_NS       = 500;
	localparam int HOLD_NS         = 500;
	localparam int ACK_WAIT_US     = 1000;
	localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_WAIT_CYC = ACK_WAIT_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W      = 24;

	// ------------------------------------------------------------
	// modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		HPP_MODE_COMPAT,
		HPP_MODE_NIBBLE,
		HPP_MODE_BYTE,
		HPP_MODE_EPP,
		HPP_MODE_ECP,
		HPP_MODE_ECP_RLE,
		HPP_MODE_FIFO,
		HPP_MODE_NEGOT
	} hpp_mode_e;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic byte_accepted;
		logic not_ready;
		logic paper_fault;
		logic online;
		logic problem;
		logic periph_valid;
	} hpp_status_s;

	typedef struct packed {
		logic choose;
		logic init;
		logic auto_feed;
		logic reverse;
	} hpp_ctrl_s;

	localparam logic [7:0] DATA_RESET = 8'h00;

endpackage : hpp_pkg

// File: hpp_port.sv
// host side signalling engine of the 1284 parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_port
	import hpp_pkg::*;
#(
	parameter int ACK_TIMEOUT = hpp_pkg::ACK_WAIT_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// user control
	input  wire hpp_pkg::hpp_mode_e mode,
	input  wire hpp_pkg::hpp_ctrl_s ctrl,
	input  wire logic              host_ready,
	// user transmit stream
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic [7:0]        tx_data,
	// user receive stream
	output logic                   rx_valid,
	output logic [7:0]             rx_data,
	// status and events
	output hpp_pkg::hpp_status_s   status,
	output logic                   ack_seen,
	output logic                   ack_timeout,
	// port pins
	output logic                   data_strobe_n,
	output logic                   auto_feed_n,
	output logic                   peripheral_init_n_o,
	output logic                   peripheral_init_n_oe_n,
	input  wire logic              peripheral_init_n_i,
	output logic                   peripheral_choose_n,
	input  wire logic              byte_accepted_n,
	input  wire logic              peripheral_not_ready,
	input  wire logic              paper_path_fault,
	input  wire logic              peripheral_online,
	input  wire logic              peripheral_problem_n,
	input  wire logic [7:0]        port_data_lines_i,
	output logic [7:0]             port_data_lines_o,
	output logic                   port_data_lines_oe_n,
	output logic                   transfer_direction,
	input  wire logic              peripheral_valid,
	output logic                   host_valid
);

	// ------------------------------------------------------------
	// types and state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_ACK
	} hpp_state_e;

	hpp_state_e          state_q;
	logic [CNT_W-1:0]    cnt_q;
	logic [7:0]          out_byte_q;
	hpp_status_s         sync1_q;
	hpp_status_s         sync2_q;
	logic                ack_prev_q;
	logic                ack_fall;
	logic                buf_valid;
	logic                buf_ready;
	logic [7:0]          buf_data;
	logic                host_drives;
	logic                reverse;
	hpp_status_s         raw;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n - 1);
	endfunction : cyc

	// ------------------------------------------------------------
	// buffer in front of the port
	// ------------------------------------------------------------
	hpp_skid #(.WIDTH(8)) u_skid (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (buf_valid),
		.out_ready (buf_ready),
		.out_data  (buf_data)
	);

	// ------------------------------------------------------------
	// status synchroniser
	// ------------------------------------------------------------
	assign raw.byte_accepted = ~byte_accepted_n;
	assign raw.not_ready     = peripheral_not_ready;
	assign raw.paper_fault   = paper_path_fault;
	assign raw.online        = peripheral_online;
	assign raw.problem       = ~peripheral_problem_n;
	assign raw.periph_valid  = peripheral_valid;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_q    <= '0;
			sync2_q    <= '0;
			ack_prev_q <= 1'b0;
		end else begin
			sync1_q    <= raw;
			sync2_q    <= sync1_q;
			ack_prev_q <= sync2_q.byte_accepted;
		end
	end

	assign ack_fall = sync2_q.byte_accepted && !ack_prev_q;

	// ------------------------------------------------------------
	// direction decode
	// ------------------------------------------------------------
	// byte, epp, ecp and fifo turn around on request; nibble never drives
	always_comb begin
		reverse = 1'b0;
		case (mode)
			HPP_MODE_COMPAT, HPP_MODE_NEGOT: reverse = 1'b0;
			HPP_MODE_NIBBLE:                 reverse = 1'b1;
			default:                         reverse = ctrl.reverse;
		endcase
	end
	assign host_drives = !reverse;

	// ------------------------------------------------------------
	// forward handshake
	// ------------------------------------------------------------
	// only peripheral-valid status lets a byte start, so a powered-off
	// printer cannot swallow data
	assign buf_ready = (state_q == ST_IDLE) && host_drives &&
		!sync2_q.not_ready && sync2_q.periph_valid;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q     <= ST_IDLE;
			cnt_q       <= '0;
			out_byte_q  <= DATA_RESET;
			ack_seen    <= 1'b0;
			ack_timeout <= 1'b0;
		end else begin
			ack_seen    <= 1'b0;
			ack_timeout <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (buf_valid && buf_ready) begin
						out_byte_q <= buf_data;
						cnt_q      <= cyc(SETUP_CYC);
						state_q    <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_q == '0) begin
						cnt_q   <= cyc(STROBE_CYC);
						state_q <= ST_STROBE;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				ST_STROBE: begin
					if (cnt_q == '0) begin
						cnt_q   <= cyc(HOLD_CYC);
						state_q <= ST_HOLD;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				ST_HOLD: begin
					if (cnt_q == '0) begin
						cnt_q   <= cyc(ACK_TIMEOUT);
						state_q <= ST_ACK;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				ST_ACK: begin
					if (ack_fall) begin
						ack_seen <= 1'b1;
						state_q  <= ST_IDLE;
					end else if (cnt_q == '0) begin
						ack_timeout <= 1'b1;
						state_q     <= ST_IDLE;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			data_strobe_n          <= 1'b1;
			auto_feed_n            <= 1'b1;
			peripheral_init_n_o    <= 1'b0;
			peripheral_init_n_oe_n <= 1'b1;
			peripheral_choose_n    <= 1'b1;
			port_data_lines_o      <= DATA_RESET;
			port_data_lines_oe_n   <= 1'b1;
			transfer_direction     <= 1'b1;
			host_valid             <= 1'b0;
		end else begin
			data_strobe_n          <= !(state_q == ST_STROBE);
			auto_feed_n            <= !ctrl.auto_feed;
			peripheral_init_n_o    <= 1'b0;
			peripheral_init_n_oe_n <= !ctrl.init;
			peripheral_choose_n    <= !ctrl.choose;
			port_data_lines_o      <= out_byte_q;
			port_data_lines_oe_n   <= !host_drives;
			transfer_direction     <= host_drives;
			host_valid             <= host_ready;
		end
	end

	// ------------------------------------------------------------
	// reverse capture and status out
	// ------------------------------------------------------------
	// reverse bytes are sampled on the acknowledge edge; in nibble mode
	// rx_data still loads but rx_valid stays low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_valid <= 1'b0;
			rx_data  <= DATA_RESET;
			status   <= '0;
		end else begin
			rx_valid <= reverse && ack_fall && (mode != HPP_MODE_NIBBLE);
			if (reverse && ack_fall)
				rx_data <= port_data_lines_i;
			status <= sync2_q;
		end
	end

endmodule : hpp_port
`default_nettype wire

// File: hpp_port_assertions.sv
// concurrent checks on the host parallel port pins
`timescale 1ns/1ps
`default_nettype none
module hpp_port_chk
	import hpp_pkg::*;
#(
	parameter int ACK_TIMEOUT = 20
) (
	// clock and reset
	input	wire logic			clk,
	input	wire logic			reset,
	// user side
	input	wire hpp_pkg::hpp_ctrl_s	ctrl,
	input	wire logic			host_ready,
	input	wire hpp_pkg::hpp_status_s	status,
	input	wire logic			ack_seen,
	input	wire logic			ack_timeout,
	// port pins
	input	wire logic			data_strobe_n,
	input	wire logic			auto_feed_n,
	input	wire logic			peripheral_init_n_o,
	input	wire logic			peripheral_init_n_oe_n,
	input	wire logic			peripheral_choose_n,
	input	wire logic			peripheral_online,
	input	wire logic			peripheral_problem_n,
	input	wire logic [7:0]		port_data_lines_o,
	input	wire logic			port_data_lines_oe_n,
	input	wire logic			transfer_direction,
	input	wire logic			host_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [2:0]	age_q;
	logic		wait_q;
	// keeps $past from looking into the reset period
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			age_q <= 3'h0;
		else if (age_q != 3'h4)
			age_q <= age_q + 3'h1;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			wait_q <= 1'b0;
		else if ($rose(data_strobe_n))
			wait_q <= 1'b1;
		else if (ack_seen || ack_timeout)
			wait_q <= 1'b0;
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	chk_choose_follow: assert property (
		age_q != 3'h0 |-> peripheral_choose_n == !$past(ctrl.choose))
		else $error("choose pin mismatch");
	chk_feed_follow: assert property (
		age_q != 3'h0 |-> auto_feed_n == !$past(ctrl.auto_feed))
		else $error("auto feed pin mismatch");
	chk_init_drain: assert property (
		age_q != 3'h0 |-> !peripheral_init_n_o
		&& peripheral_init_n_oe_n == !$past(ctrl.init))
		else $error("init pin mismatch");
	chk_host_valid: assert property (
		age_q != 3'h0 |-> host_valid == $past(host_ready))
		else $error("host valid mismatch");
	chk_strobe_width: assert property (
		$fell(data_strobe_n) |-> ##50 $rose(data_strobe_n))
		else $error("strobe width wrong");
	chk_strobe_data: assert property (
		!data_strobe_n |-> $stable(port_data_lines_o)
		&& !port_data_lines_oe_n && transfer_direction)
		else $error("data not held during strobe");
	chk_ack_order: assert property (
		$fell(data_strobe_n) |-> !wait_q)
		else $error("byte started before ack");
	chk_status_sync: assert property (
		age_q == 3'h4 |-> status.online == $past(peripheral_online, 3)
		&& status.problem == !$past(peripheral_problem_n, 3))
		else $error("status not synchronised");
	cover property ($fell(data_strobe_n));
	cover property (ack_seen);
	cover property (ack_timeout);
endmodule : hpp_port_chk
bind hpp_port hpp_port_chk #(.ACK_TIMEOUT(ACK_TIMEOUT)) hpp_port_chk_i (.*);
`default_nettype wire

// File: hpp_skid.sv
// two-entry buffer carrying bytes toward the port
`timescale 1ns/1ps
`default_nettype none
module hpp_skid #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_q     <= 1'b0;
			rd_q     <= 1'b0;
			cnt_q    <= 2'h0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			// ready is a flop so the port output is registered
			if (push && !pop) begin
				cnt_q    <= cnt_q + 2'h1;
				in_ready <= (cnt_q != 2'h1);
			end else if (pop && !push) begin
				cnt_q    <= cnt_q - 2'h1;
				in_ready <= 1'b1;
			end
		end
	end
endmodule : hpp_skid
`default_nettype wire

// File: test_ieee1284_host_port_signalling.sv
// self-checking bench for the host parallel port
`timescale 1ns/1ps
`default_nettype none
module test_ieee1284_host_port_signalling;
	import hpp_pkg::*;
	typedef struct packed {
		logic [3:0]	c;
		logic [3:0]	pin;
		logic [3:0]	eo;
		logic [5:0]	es;
	} hpp_row_s;
	logic clk = 1'b0, reset = 1'b1, host_ready = 1'b0, tx_valid = 1'b0;
	logic hold_busy = 1'b0, go_online = 1'b0, jam = 1'b0, fail = 1'b0;
	logic powered = 1'b1, answer = 1'b1, slow = 1'b0, stb_q = 1'b1;
	logic send = 1'b0;
	logic [7:0] tx_data = 8'h00;
	hpp_mode_e mode = HPP_MODE_COMPAT;
	hpp_ctrl_s ctrl = '0;
	hpp_status_s status;
	wire tx_ready, rx_valid, ack_seen, ack_timeout, data_strobe_n;
	wire auto_feed_n, peripheral_init_n_o, peripheral_init_n_oe_n;
	wire peripheral_init_n_i, peripheral_choose_n, byte_accepted_n;
	wire peripheral_not_ready, paper_path_fault, peripheral_online;
	wire peripheral_problem_n, peripheral_valid, host_valid;
	wire port_data_lines_oe_n, transfer_direction;
	wire [7:0] rx_data, port_data_lines_o, port_data_lines_i, data_drv;
	int n_mismatch = 0, tests_run = 0, n_ack = 0, n_to = 0, cyc = 0;
	logic [7:0] log_q[$];
	logic [7:0] exp_b [5] = '{8'hA5, 8'h3C, 8'h0F, 8'h81, 8'h7E};
	// ctrl {choose,init,feed,rev}, pins {ready,online,jam,fail}
	hpp_row_s rows [4] = '{{4'h8, 4'hC, 4'h7, 6'h05},
		{4'h4, 4'h2, 4'hC, 6'h0B}, {4'h2, 4'hD, 4'hB, 6'h07},
		{4'hE, 4'h0, 4'h0, 6'h01}};
	assign port_data_lines_i = port_data_lines_oe_n ? data_drv
		: port_data_lines_o;
	assign peripheral_init_n_i = peripheral_init_n_oe_n | peripheral_init_n_o;
	hpp_port #(.ACK_TIMEOUT(40)) hpp_port_i (.*);
	hpp_periph_model hpp_periph_model_i (.*);
	always #5 clk = ~clk;
	always @(negedge clk) begin
		stb_q <= data_strobe_n;
		if (data_strobe_n && !stb_q)
			log_q.push_back(port_data_lines_o);
		if (ack_seen)
			n_ack++;
		if (ack_timeout)
			n_to++;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic push(input logic [7:0] b);
		tick(1);
		tx_valid = 1'b1;
		tx_data = b;
		while (tx_ready !== 1'b1)
			tick(1);
		tick(1);
		tx_valid = 1'b0;
	endtask : push
	task automatic wait_log(input int n);
		int g;
		g = 0;
		while (log_q.size() < n && g < 1500) begin
			tick(1);
			g++;
		end
	endtask : wait_log
	task automatic finish_test();
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	initial begin
		tick(6);
		chk(16'({data_strobe_n, auto_feed_n, peripheral_init_n_oe_n,
			peripheral_choose_n, port_data_lines_oe_n, transfer_direction,
			host_valid}), 16'h007E);
		chk(16'(status), 16'h0000);
		tick(6);
		reset = 1'b0;
		foreach (rows[i]) begin
			ctrl = hpp_ctrl_s'(rows[i].c);
			{host_ready, go_online, jam, fail} = rows[i].pin;
			tick(5);
			chk(16'({peripheral_choose_n, auto_feed_n, peripheral_init_n_oe_n,
				host_valid}), 16'(rows[i].eo));
			chk(16'(status), 16'(rows[i].es));
		end
		ctrl = hpp_ctrl_s'(4'h1);
		for (int m = 0; m < 8; m++) begin
			mode = hpp_mode_e'(m);
			tick(3);
			chk(16'(port_data_lines_oe_n), 16'(m != 0 && m != 7));
			if (m != 1)
				chk(16'(transfer_direction), 16'(m == 0 || m == 7));
		end
		mode = HPP_MODE_COMPAT;
		ctrl = hpp_ctrl_s'(4'h8);
		host_ready = 1'b1;
		hold_busy = 1'b1;
		slow = 1'b1;
		push(8'hA5);
		push(8'h3C);
		tick(4);
		chk(16'(tx_ready), 16'h0000);
		chk(16'(log_q.size()), 16'h0000);
		hold_busy = 1'b0;
		push(8'h0F);
		wait_log(3);
		slow = 1'b0;
		tick(120);
		answer = 1'b0;
		push(8'h81);
		wait_log(4);
		tick(150);
		answer = 1'b1;
		push(8'h7E);
		wait_log(5);
		tick(150);
		chk(16'(n_to), 16'h0001);
		chk(16'(n_ack), 16'h0004);
		chk(16'(log_q.size()), 16'h0005);
		foreach (exp_b[i])
			chk(16'(log_q[i]), 16'(exp_b[i]));
		// reverse byte captured on the acknowledge edge
		mode = HPP_MODE_BYTE;
		ctrl = hpp_ctrl_s'(4'h1);
		tick(3);
		send = 1'b1;
		for (int g = 0; g < 200 && rx_valid !== 1'b1; g++)
			tick(1);
		chk(16'({rx_valid, rx_data}), 16'h01C6);
		send = 1'b0;
		finish_test();
	end
endmodule : test_ieee1284_host_port_signalling
`default_nettype wire
